// [rtl/rgc_pkg.sv]
// Package with register map, field layout and reset values of the regulator control group
// Notes on behaviour
// (R1) Boost standby mode bits 6:5 pick off, PFM, automatic or pulse skipping.
// (R2) Boost normal mode bits 3:2 use the same four codes, 00 meaning off.
// (R3) Boost voltage bits 1:0 step from 5.000 V at 00 to 5.150 V at 11.
// (R4) In automatic mode the boost picks PFM or pulse skipping from load current.
// (R5) Boost enters automatic switching when the power-up sequence enables it; the code sets only normal mode bits 3:2, standby still uses bits 6:5.
// (R6) Front-end regulator bit 0 set keeps it at full power in standby.
// (R7) Memory reference enable bit 0 turns the reference supply on or off.
// (R8) Backup supply voltage accepts only code 110, meaning 3.0 V; others are refused.
// (R9) Linear regulator bit 7 picks off or sleep on a power-button turn-off.
// (R10) Linear regulator bit 6 set permits low-power operation; clear forbids it.
// (R11) Linear regulator bit 5 set switches it off during standby.
// (R12) Linear regulator bit 4 enables the regulator.
// (R13) Linear regulator bits 3:0 hold the four-bit output voltage code.
// (R14) Second linear regulator register has the same layout as the first.
// (R15) At reset linear bits 7:5 are 0; enable and voltage load from OTP.
// (R16) Unimplemented bits read as zero and ignore writes.
package rgc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int LDO_N = 2;

   localparam logic [7:0] OFS_BOOST = 8'h66;
   localparam logic [7:0] OFS_FRONT = 8'h69;
   localparam logic [7:0] OFS_MEMREF = 8'h6A;
   localparam logic [7:0] OFS_BACKUP = 8'h6B;
   localparam logic [7:0] OFS_LDO_A = 8'h6C;
   localparam logic [7:0] OFS_LDO_B = 8'h6D;

   localparam int BOOST_STBY_LSB = 5;
   localparam int BOOST_NORM_LSB = 2;
   localparam int BOOST_VOLT_LSB = 0;
   localparam int LDO_OMODE_BIT = 7;
   localparam int LDO_LPWR_BIT = 6;
   localparam int LDO_STBY_BIT = 5;
   localparam int LDO_EN_BIT = 4;
   localparam int LDO_VOLT_LSB = 0;

   localparam logic [7:0] BOOST_MASK = 8'h6F;
   localparam logic [7:0] FRONT_MASK = 8'h01;
   localparam logic [7:0] MEMREF_MASK = 8'h01;
   localparam logic [7:0] BACKUP_MASK = 8'h07;
   localparam logic [7:0] LDO_MASK = 8'hFF;

   localparam logic [7:0] BOOST_RST = 8'h00;
   localparam logic FRONT_RST = 1'h0;
   localparam logic MEMREF_RST = 1'h0;
   localparam logic [2:0] BACKUP_3V0 = 3'h6;
   localparam logic [2:0] LDO_CTRL_RST = 3'h0;

   typedef enum logic [1:0] {
      BST_OFF = 2'b00,
      BST_PFM = 2'b01,
      BST_AUTO = 2'b10,
      BST_PSM = 2'b11
   } rgc_boost_mode_type;
endpackage

// [rtl/rgc_regulator_control_regs.sv]
// Regulator control register group with its decoded regulator controls
`timescale 1ns/10ps
`default_nettype none
module rgc_regulator_control_regs #(
   parameter int LDO_N = rgc_pkg::LDO_N
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [rgc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [rgc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output logic [rgc_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rd_valid,
   input wire logic [LDO_N-1:0] otp_ldo_enable,
   input wire logic [4*LDO_N-1:0] otp_ldo_voltage,
   input wire logic device_standby,
   input wire logic seq_boost_enable,
   input wire logic boost_load_high,
   input wire logic power_button_turnoff,
   input wire logic power_button_wake,
   output logic boost_on,
   output logic boost_pfm_active,
   output logic boost_psm_active,
   output logic [1:0] boost_voltage_code,
   output logic front_ldo_low_power,
   output logic memory_reference_enable,
   output logic [2:0] backup_supply_voltage_code,
   output logic [LDO_N-1:0] linear_reg_on,
   output logic [LDO_N-1:0] linear_reg_low_power,
   output logic [LDO_N-1:0] linear_reg_sleep,
   output logic [4*LDO_N-1:0] linear_reg_voltage_code
);
   import rgc_pkg::*;

   logic [7:0] boost_ctl_ff;
   logic front_full_power_ff;
   logic memref_en_ff;
   logic [2:0] backup_volt_ff;
   logic [7:0] ldo_ctl_ff [LDO_N];
   logic [LDO_N-1:0] ldo_down_ff;
   logic [LDO_N-1:0] ldo_sleep_ff;
   logic [7:0] nxt_rdata;
   logic [1:0] boost_sel_mode;
   logic wr_boost;
   logic wr_front;
   logic wr_memref;
   logic wr_backup;

   // Address match for one register offset
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   assign wr_boost = reg_wr_en && hit(reg_addr, OFS_BOOST);
   assign wr_front = reg_wr_en && hit(reg_addr, OFS_FRONT);
   assign wr_memref = reg_wr_en && hit(reg_addr, OFS_MEMREF);
   assign wr_backup = reg_wr_en && hit(reg_addr, OFS_BACKUP);

   // Boost control; the sequencer start wins over a host write in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         boost_ctl_ff <= BOOST_RST;
      end else if (seq_boost_enable) begin
         boost_ctl_ff[BOOST_NORM_LSB +: 2] <= BST_AUTO; // [R5]
      end else if (wr_boost) begin
         boost_ctl_ff <= reg_wdata & BOOST_MASK; // [R16]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         front_full_power_ff <= FRONT_RST;
      end else if (wr_front) begin
         front_full_power_ff <= reg_wdata[0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         memref_en_ff <= MEMREF_RST;
      end else if (wr_memref) begin
         memref_en_ff <= reg_wdata[0]; // [R7]
      end
   end

   // Reserved codes would drive the backup rail out of range, so they are dropped
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         backup_volt_ff <= BACKUP_3V0;
      end else if (wr_backup && (reg_wdata[2:0] == BACKUP_3V0)) begin
         backup_volt_ff <= reg_wdata[2:0]; // [R8]
      end
   end

   // Boost mode selection: standby field while the device is in standby
   always_comb begin
      if (device_standby) begin
         boost_sel_mode = boost_ctl_ff[BOOST_STBY_LSB +: 2]; // [R1]
      end else begin
         boost_sel_mode = boost_ctl_ff[BOOST_NORM_LSB +: 2]; // [R2]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         boost_on <= 1'b0;
         boost_pfm_active <= 1'b0;
         boost_psm_active <= 1'b0;
      end else begin
         boost_on <= (boost_sel_mode != BST_OFF); // [R1] [R2]
         unique case (boost_sel_mode)
            BST_OFF: begin
               boost_pfm_active <= 1'b0;
               boost_psm_active <= 1'b0;
            end
            BST_PFM: begin
               boost_pfm_active <= 1'b1;
               boost_psm_active <= 1'b0;
            end
            BST_AUTO: begin
               boost_pfm_active <= !boost_load_high; // [R4]
               boost_psm_active <= boost_load_high; // [R4]
            end
            BST_PSM: begin
               boost_pfm_active <= 1'b0;
               boost_psm_active <= 1'b1;
            end
         endcase
      end
   end

   assign boost_voltage_code = boost_ctl_ff[BOOST_VOLT_LSB +: 2]; // [R3]
   assign front_ldo_low_power = device_standby && !front_full_power_ff; // [R6]
   assign memory_reference_enable = memref_en_ff; // [R7]
   assign backup_supply_voltage_code = backup_volt_ff; // [R8]

   // Both linear regulators share one layout
   genvar gi;
   generate
      for (gi = 0; gi < LDO_N; gi++) begin : g_ldo
         logic wr_ldo;
         logic [7:0] ctl;
         assign wr_ldo = reg_wr_en && hit(reg_addr, OFS_LDO_A + 8'(gi)); // [R14]
         assign ctl = ldo_ctl_ff[gi];

         // Reset is synchronous, so sampling the OTP lines here is safe
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               ldo_ctl_ff[gi] <= {LDO_CTRL_RST, otp_ldo_enable[gi],
                                  otp_ldo_voltage[4*gi +: 4]}; // [R15]
            end else if (wr_ldo) begin
               ldo_ctl_ff[gi] <= reg_wdata & LDO_MASK; // [R13]
            end
         end

         // Turn-off event: off or sleep from bit 7; a wake in the same cycle loses
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               ldo_down_ff[gi] <= 1'b0;
               ldo_sleep_ff[gi] <= 1'b0;
            end else if (power_button_turnoff) begin
               ldo_down_ff[gi] <= !ctl[LDO_OMODE_BIT]; // [R9]
               ldo_sleep_ff[gi] <= ctl[LDO_OMODE_BIT]; // [R9]
            end else if (power_button_wake) begin
               ldo_down_ff[gi] <= 1'b0;
               ldo_sleep_ff[gi] <= 1'b0;
            end
         end

         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               linear_reg_on[gi] <= 1'b0;
               linear_reg_low_power[gi] <= 1'b0;
            end else begin
               linear_reg_on[gi] <= ctl[LDO_EN_BIT] && !ldo_down_ff[gi] &&
                  !(device_standby && ctl[LDO_STBY_BIT]); // [R11] [R12]
               linear_reg_low_power[gi] <= ctl[LDO_LPWR_BIT] &&
                  (device_standby || ldo_sleep_ff[gi]); // [R10]
            end
         end

         assign linear_reg_sleep[gi] = ldo_sleep_ff[gi]; // [R9]
         assign linear_reg_voltage_code[4*gi +: 4] = ctl[LDO_VOLT_LSB +: 4]; // [R13]
      end
   endgenerate

   // Read mux; unmapped offsets and unimplemented bits read as zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (hit(reg_addr, OFS_BOOST)) begin
         nxt_rdata = boost_ctl_ff & BOOST_MASK; // [R16]
      end else if (hit(reg_addr, OFS_FRONT)) begin
         nxt_rdata = {7'h00, front_full_power_ff}; // [R16]
      end else if (hit(reg_addr, OFS_MEMREF)) begin
         nxt_rdata = {7'h00, memref_en_ff};
      end else if (hit(reg_addr, OFS_BACKUP)) begin
         nxt_rdata = {5'h00, backup_volt_ff};
      end else begin
         for (int i = 0; i < LDO_N; i++) begin
            if (hit(reg_addr, OFS_LDO_A + 8'(i))) begin
               nxt_rdata = ldo_ctl_ff[i]; // [R14]
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata <= nxt_rdata;
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/rgc_checker.sv]
// Port checks for the regulator control registers
`timescale 1ns/10ps
`default_nettype none
module rgc_checker import rgc_pkg::*; #(parameter int LDO_N = 2) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rdata,
   input wire logic device_standby,
   input wire logic seq_boost_enable,
   input wire logic boost_on,
   input wire logic boost_pfm_active,
   input wire logic boost_psm_active,
   input wire logic [1:0] boost_voltage_code,
   input wire logic front_ldo_low_power,
   input wire logic memory_reference_enable,
   input wire logic [2:0] backup_supply_voltage_code,
   input wire logic [4*LDO_N-1:0] linear_reg_voltage_code
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_boost_volt: assert property (reg_wr_en && reg_addr == OFS_BOOST && !seq_boost_enable
      |=> boost_voltage_code == $past(reg_wdata[1:0])) else $error("boost voltage lost");
   a_boost_mode_one: assert property (boost_pfm_active || boost_psm_active
      |-> boost_on && !(boost_pfm_active && boost_psm_active)) else $error("boost mode clash");
   a_front_low: assert property (reg_wr_en && reg_addr == OFS_FRONT
      |=> front_ldo_low_power == (device_standby && !$past(reg_wdata[0]))) else $error("front");
   a_memref_en: assert property (reg_wr_en && reg_addr == OFS_MEMREF
      |=> memory_reference_enable == $past(reg_wdata[0])) else $error("memref enable");
   a_backup_fixed: assert property (backup_supply_voltage_code == 3'h6) else $error("backup");
   a_ldo_a_code: assert property (reg_wr_en && reg_addr == OFS_LDO_A
      |=> linear_reg_voltage_code[3:0] == $past(reg_wdata[3:0])) else $error("ldo a code");
   a_ldo_b_code: assert property (reg_wr_en && reg_addr == OFS_LDO_B
      |=> linear_reg_voltage_code[7:4] == $past(reg_wdata[3:0])) else $error("ldo b code");
   a_unimpl_zero: assert property (reg_rd_en && reg_addr == OFS_BOOST
      |=> (reg_rdata & ~BOOST_MASK) == 8'h00) else $error("unused bits set");
   c_psm: cover property (boost_psm_active);
   c_pfm: cover property (boost_pfm_active);
   c_backup_wr: cover property (reg_wr_en && reg_addr == OFS_BACKUP);
endmodule
bind rgc_regulator_control_regs rgc_checker #(.LDO_N(LDO_N)) rgc_checker_i (.*);
`default_nettype wire

// [testbench/rgc_host.sv]
// Host model driving the register strobe port
`timescale 1ns/10ps
`default_nettype none
module rgc_host (
   input wire logic core_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr_en,
   output logic reg_rd_en,
   input wire logic [7:0] reg_rdata
);
   initial {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = 18'h0;
   // Released lines show the inverse so stale values cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1 {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
      @(posedge core_clk);
      #1 {reg_addr, reg_wdata, reg_wr_en} = {~a, ~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1 {reg_addr, reg_rd_en} = {a, 1'b1};
      @(posedge core_clk);
      #1 {reg_addr, reg_rd_en} = {~a, 1'b0};
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// [testbench/tb_regulator_control_regs.sv]
// Self-checking bench for the regulator control registers
`timescale 1ns/10ps
`default_nettype none
module tb_regulator_control_regs import rgc_pkg::*;;
   logic core_clk = 0, rst_n = 0, reg_wr_en, reg_rd_en, reg_rd_valid, boost_on;
   logic device_standby = 0, seq_boost_enable = 0, boost_load_high = 0;
   logic power_button_turnoff = 0, power_button_wake = 0, boost_pfm_active, boost_psm_active;
   logic front_ldo_low_power, memory_reference_enable;
   logic [1:0] otp_ldo_enable = 0, boost_voltage_code, linear_reg_on;
   logic [1:0] linear_reg_low_power, linear_reg_sleep;
   logic [2:0] backup_supply_voltage_code;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, otp_ldo_voltage = 0, linear_reg_voltage_code;
   logic [4:0] sb = 5'h06, tf = 5'h18;
   int lv[5] = '{8'h30, 8'h30, 8'h50, 8'hD0, 8'h10}, ex[5] = '{4, 0, 6, 7, 0};
   int fails = 0, total_checks = 0, cyc = 0, m[256];
   rgc_regulator_control_regs rgc_regulator_control_regs_i (.*);
   rgc_host rgc_host_i (.*);
   initial forever #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (++cyc > 4000) begin
         $display("Error at %0t: timeout", $time);
         close_out(1);
      end
   end
   task automatic close_out(input int extra);
      fails += extra;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input int a, input int d);
      rgc_host_i.wr(8'(a), 8'(d));
      case (a)
         OFS_BOOST: m[a] = d & BOOST_MASK;
         OFS_FRONT, OFS_MEMREF: m[a] = d & 1;
         OFS_LDO_A, OFS_LDO_B: m[a] = d & 255;
         default: ;
      endcase
   endtask
   task automatic rdc(input int a);
      logic [7:0] d;
      rgc_host_i.rd(8'(a), d);
      cmp(d, 8'(m[a]));
      cmp(8'(reg_rd_valid), 8'h01);
      @(posedge core_clk);
      #1 cmp(8'(reg_rd_valid), 8'h00);
   endtask
   initial begin
      logic [7:0] e;
      int a;
      int d;
      void'($urandom(9));
      otp_ldo_enable = 2'($urandom);
      otp_ldo_voltage = 8'($urandom);
      m[OFS_BACKUP] = 6;
      m[OFS_LDO_A] = {otp_ldo_enable[0], otp_ldo_voltage[3:0]};
      m[OFS_LDO_B] = {otp_ldo_enable[1], otp_ldo_voltage[7:4]};
      repeat (4) @(posedge core_clk);
      #1 rst_n = 1;
      for (a = 8'h64; a < 8'h70; a++) rdc(a);
      for (int i = 0; i < 60; i++) begin
         a = 8'h66 + $urandom % 8;
         d = $urandom;
         // The host never writes a reserved backup code
         if (a == OFS_BACKUP) d[2:0] = BACKUP_3V0;
         wr(a, d);
         device_standby = 1'($urandom);
         rdc(a);
         e = {1'b0, m[OFS_BOOST][1:0], m[OFS_MEMREF][0], m[OFS_BACKUP][2:0],
            device_standby & ~m[OFS_FRONT][0]};
         cmp({1'b0, boost_voltage_code, memory_reference_enable, backup_supply_voltage_code,
            front_ldo_low_power}, e);
         cmp(linear_reg_voltage_code, 8'({m[OFS_LDO_B][3:0], m[OFS_LDO_A][3:0]}));
      end
      // Bit 3 picks the standby field, bit 2 the load, bits 1:0 the mode
      for (int k = 0; k < 16; k++) begin
         device_standby = k[3];
         boost_load_high = k[2];
         wr(OFS_BOOST, k[3] ? (k & 3) << 5 : (k & 3) << 2);
         #200;
         a = k & 3;
         cmp(8'({boost_on, boost_pfm_active, boost_psm_active}), 8'({a != 0,
            a == 1 || a == 2 && !k[2], a == 3 || a == 2 && k[2]}));
      end
      seq_boost_enable = 1;
      #100 seq_boost_enable = 0;
      m[OFS_BOOST] = m[OFS_BOOST] & 8'h63 | 8'h08;
      rdc(OFS_BOOST);
      for (int i = 0; i < 2; i++) begin
         for (int s = 0; s < 5; s++) begin
            power_button_wake = 1;
            #100 power_button_wake = 0;
            device_standby = sb[s];
            wr(OFS_LDO_A + i, lv[s]);
            power_button_turnoff = tf[s];
            #100 power_button_turnoff = 0;
            #200;
            e = {linear_reg_on[i], linear_reg_low_power[i], linear_reg_sleep[i]};
            cmp(e, 8'(ex[s]));
         end
      end
      close_out(0);
   end
endmodule
`default_nettype wire
